// [logic/comparator_event_control.sv]
/*
  Comparator control and event logic: input selection, result
  synchronisation, event detection, interrupt flag and capture routing,
  with an APB register file.
  Assumes the analog comparator sits outside and reports its raw result on
  cmp_raw_i; select outputs steer the analog switches.
*/
// What this block does
// - Result high when positive input exceeds negative.
// - Result synchronised, one to two cycles late.
// - Bandgap select picks reference over positive pin.
// - Mux drives negative input if enabled, converter off.
// - Disable bit switches comparator off, anytime.
// - Flag set on event matching chosen mode.
// - Flag clears when interrupt vector executes.
// - Writing one clears flag; zero keeps it.
// - Request needs flag, enable and global enable.
// - Capture route drives timer capture front end.
// - Modes: toggle, reserved, falling, rising.
// - Channel code selects analog channel zero-seven.
module comparator_event_control (
  input  wire logic        core_clk_i,        // System clock, 125 MHz.
  input  wire logic        rst_i,             // Synchronous reset, active high.
  input  wire logic        psel_i,            // APB select.
  input  wire logic        penable_i,         // APB enable.
  input  wire logic        pwrite_i,          // APB write.
  input  wire logic [7:0]  paddr_i,           // APB byte address.
  input  wire logic [31:0] pwdata_i,          // APB write data.
  output logic      [31:0] prdata_o,          // APB read data.
  output logic             pready_o,          // APB ready.
  output logic             pslverr_o,         // APB error on unmapped address.
  input  wire logic        cmp_raw_i,         // Raw comparator result.
  input  wire logic        converter_enable_i,// Converter enable level.
  input  wire logic        global_irq_en_i,   // Processor global enable.
  input  wire logic        irq_ack_i,         // Vector executed, one pulse.
  output logic             bandgap_sel_o,     // Positive input uses bandgap.
  output logic             neg_mux_sel_o,     // Negative input uses mux.
  output logic      [2:0]  neg_channel_o,     // Mux channel number.
  output logic             cmp_power_off_o,   // Comparator powered down.
  output logic             capture_in_o,      // Timer capture input.
  output logic             capture_sel_o,     // Timer capture source select.
  output logic             cmp_irq_o,         // Comparator interrupt request.
  output logic             irq_o              // Event interrupt, level.
);
  logic                 cmp_disable;
  logic                 bandgap_select;
  logic                 cmp_irq_flag;
  logic                 cmp_irq_enable;
  logic                 capture_route_enable;
  logic [1:0]           event_mode;
  logic                 neg_input_mux_enable;
  logic [2:0]           channel_select_low;
  logic [1:0]           irq_status;
  logic [1:0]           irq_mask;
  logic                 cmp_result_bit;
  logic                 result_prev;
  logic                 change_ev;
  logic                 match_ev;
  logic                 wr_acc;
  logic                 rd_acc;
  logic                 mapped;
  logic [31:0]          next_rdata;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == cmp_event_pkg::OFF_CTRL_STATUS) || (a == cmp_event_pkg::OFF_MUX_CTRL)
           || (a == cmp_event_pkg::OFF_IRQ_STATUS)  || (a == cmp_event_pkg::OFF_IRQ_MASK);
  endfunction

  assign mapped = addr_ok(paddr_i);
  assign wr_acc = psel_i && penable_i && pwrite_i && pready_o;
  assign rd_acc = psel_i && penable_i && !pwrite_i && pready_o;

  // Disabled comparator holds the raw level low, so the result reads zero.
  result_sync u_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    (cmp_raw_i && !cmp_disable),
    .sync_o     (cmp_result_bit)
  );

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      result_prev <= 1'b0;
    end else begin
      result_prev <= cmp_result_bit;
    end
  end

  assign change_ev = cmp_result_bit ^ result_prev;

  always_comb begin
    case (cmp_event_pkg::event_mode_e'(event_mode))
      cmp_event_pkg::MODE_TOGGLE:   match_ev = change_ev;
      cmp_event_pkg::MODE_FALLING:  match_ev = change_ev && !cmp_result_bit;
      cmp_event_pkg::MODE_RISING:   match_ev = change_ev && cmp_result_bit;
      cmp_event_pkg::MODE_RESERVED: match_ev = 1'b0;
      default:                      match_ev = 1'b0;
    endcase
  end

  // Control fields. The result bit position is never written.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cmp_disable          <= cmp_event_pkg::CTRL_RESET[cmp_event_pkg::BIT_DISABLE];
      bandgap_select       <= cmp_event_pkg::CTRL_RESET[cmp_event_pkg::BIT_BANDGAP];
      cmp_irq_enable       <= cmp_event_pkg::CTRL_RESET[cmp_event_pkg::BIT_IRQ_EN];
      capture_route_enable <= cmp_event_pkg::CTRL_RESET[cmp_event_pkg::BIT_CAPTURE];
      event_mode           <= cmp_event_pkg::CTRL_RESET[1:0];
    end else if (wr_acc && paddr_i == cmp_event_pkg::OFF_CTRL_STATUS) begin
      cmp_disable          <= pwdata_i[cmp_event_pkg::BIT_DISABLE];
      bandgap_select       <= pwdata_i[cmp_event_pkg::BIT_BANDGAP];
      cmp_irq_enable       <= pwdata_i[cmp_event_pkg::BIT_IRQ_EN];
      capture_route_enable <= pwdata_i[cmp_event_pkg::BIT_CAPTURE];
      event_mode           <= {pwdata_i[cmp_event_pkg::BIT_MODE_HI], pwdata_i[cmp_event_pkg::BIT_MODE_LO]};
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      neg_input_mux_enable <= cmp_event_pkg::MUX_RESET[cmp_event_pkg::BIT_MUX_EN];
      channel_select_low   <= cmp_event_pkg::MUX_RESET[2:0];
    end else if (wr_acc && paddr_i == cmp_event_pkg::OFF_MUX_CTRL) begin
      neg_input_mux_enable <= pwdata_i[cmp_event_pkg::BIT_MUX_EN];
      channel_select_low   <= pwdata_i[cmp_event_pkg::BIT_CHAN_LSB +: cmp_event_pkg::CHAN_WIDTH];
    end
  end

  // Interrupt flag: a new event wins over a same-cycle clear.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cmp_irq_flag <= cmp_event_pkg::CTRL_RESET[cmp_event_pkg::BIT_FLAG];
    end else if (match_ev) begin
      cmp_irq_flag <= 1'b1;
    end else if (irq_ack_i) begin
      cmp_irq_flag <= 1'b0;
    end else if (wr_acc && paddr_i == cmp_event_pkg::OFF_CTRL_STATUS && pwdata_i[cmp_event_pkg::BIT_FLAG]) begin
      cmp_irq_flag <= 1'b0;
    end
  end

  // Sticky event status cleared by reading it; events in the read cycle survive.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_status <= '0;
    end else begin
      if (rd_acc && paddr_i == cmp_event_pkg::OFF_IRQ_STATUS) begin
        irq_status <= {match_ev, change_ev};
      end else begin
        irq_status <= irq_status | {match_ev, change_ev};
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_mask <= cmp_event_pkg::IRQ_MASK_RESET;
    end else if (wr_acc && paddr_i == cmp_event_pkg::OFF_IRQ_MASK) begin
      irq_mask <= pwdata_i[cmp_event_pkg::IRQ_WIDTH-1:0];
    end
  end

  // Outputs are registered, so each follows its source one cycle later.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      bandgap_sel_o   <= 1'b0;
      neg_mux_sel_o   <= 1'b0;
      neg_channel_o   <= 3'h0;
      cmp_power_off_o <= 1'b0;
      capture_in_o    <= 1'b0;
      capture_sel_o   <= 1'b0;
      cmp_irq_o       <= 1'b0;
      irq_o           <= 1'b0;
    end else begin
      bandgap_sel_o   <= bandgap_select;
      neg_mux_sel_o   <= neg_input_mux_enable && !converter_enable_i;
      neg_channel_o   <= channel_select_low;
      cmp_power_off_o <= cmp_disable;
      capture_in_o    <= capture_route_enable && cmp_result_bit;
      capture_sel_o   <= capture_route_enable;
      cmp_irq_o       <= cmp_irq_flag && cmp_irq_enable && global_irq_en_i;
      irq_o           <= |(irq_status & irq_mask);
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (paddr_i)
      cmp_event_pkg::OFF_CTRL_STATUS: begin
        next_rdata[7:0] = {cmp_disable, bandgap_select, cmp_result_bit, cmp_irq_flag,
                           cmp_irq_enable, capture_route_enable, event_mode};
      end
      cmp_event_pkg::OFF_MUX_CTRL: next_rdata[3:0] = {neg_input_mux_enable, channel_select_low};
      cmp_event_pkg::OFF_IRQ_STATUS: next_rdata[1:0] = irq_status;
      cmp_event_pkg::OFF_IRQ_MASK: next_rdata[1:0] = irq_mask;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // One wait state: ready rises in the second access cycle, then drops.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (psel_i && penable_i && !pready_o) begin
      pready_o  <= 1'b1;
      prdata_o  <= pwrite_i ? 32'h0000_0000 : next_rdata;
      pslverr_o <= !mapped;
    end else begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
  end
endmodule

// [logic/cmp_event_pkg.sv]
/*
  Package for the comparator event block: register offsets, field positions,
  reset values and event modes.
  Assumes a 32-bit APB slave with one register per aligned word.
*/
package cmp_event_pkg;
  localparam logic [7:0] OFF_CTRL_STATUS = 8'h00;
  localparam logic [7:0] OFF_MUX_CTRL    = 8'h04;
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK    = 8'h0C;

  localparam int BIT_DISABLE   = 7;
  localparam int BIT_BANDGAP   = 6;
  localparam int BIT_RESULT    = 5;
  localparam int BIT_FLAG      = 4;
  localparam int BIT_IRQ_EN    = 3;
  localparam int BIT_CAPTURE   = 2;
  localparam int BIT_MODE_HI   = 1;
  localparam int BIT_MODE_LO   = 0;

  localparam int BIT_MUX_EN    = 3;
  localparam int BIT_CHAN_LSB  = 0;
  localparam int CHAN_WIDTH    = 3;

  localparam int BIT_EV_CHANGE = 0;
  localparam int BIT_EV_FLAG   = 1;
  localparam int IRQ_WIDTH     = 2;

  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [3:0] MUX_RESET      = 4'h0;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

  typedef enum logic [1:0] {
    MODE_TOGGLE   = 2'b00,
    MODE_RESERVED = 2'b01,
    MODE_FALLING  = 2'b10,
    MODE_RISING   = 2'b11
  } event_mode_e;
endpackage

// [logic/result_sync.sv]
/*
  Two-flop synchroniser for the raw comparator result.
  Assumes the input is asynchronous to core_clk_i.
*/
module result_sync (
  input  wire logic core_clk_i, // System clock.
  input  wire logic rst_i,      // Synchronous reset, active high.
  input  wire logic async_i,    // Raw asynchronous level.
  output logic      sync_o      // Synchronised level.
);
  logic meta;

  // The first stage feeds only the second stage, never any logic.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      meta   <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule

// [dv/analog_front_model.sv]
/* Analog side of the comparator: input selection and compare.
   Assumes channel n of the converter mux sits at n * 0.5 V. */
module analog_front_model (
  input  wire logic       bandgap_sel_i, // Bandgap on plus.
  input  wire logic       neg_mux_sel_i, // Mux on minus.
  input  wire logic [2:0] neg_channel_i, // Channel code.
  input  wire logic       power_off_i,   // Powered down.
  input  var  real        pos_pin_v_i,   // Plus pin volts.
  input  var  real        neg_pin_v_i,   // Minus pin volts.
  output logic            cmp_raw_o      // Raw result.
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam real BANDGAP_V = 1.1;
  real pos_v, neg_v;
  always_comb begin
    pos_v = bandgap_sel_i ? BANDGAP_V : pos_pin_v_i;
    neg_v = neg_mux_sel_i ? 0.5 * neg_channel_i : neg_pin_v_i;
    cmp_raw_o = !power_off_i && (pos_v > neg_v);
  end
endmodule

// [dv/comparator_event_control_monitor.sv]
/* Port checker for the comparator event block.
   Assumes it is bound to the top module and sees its ports only. */
module comparator_event_control_monitor (
  input wire logic       core_clk_i,         // Clock.
  input wire logic       rst_i,              // Reset.
  input wire logic       pwrite_i,           // Seen.
  input wire logic       pready_o,           // Seen.
  input wire logic       cmp_raw_i,          // Seen.
  input wire logic       converter_enable_i, // Seen.
  input wire logic       global_irq_en_i,    // Seen.
  input wire logic       bandgap_sel_o,      // Seen.
  input wire logic       neg_mux_sel_o,      // Seen.
  input wire logic [2:0] neg_channel_o,      // Seen.
  input wire logic       cmp_power_off_o,    // Seen.
  input wire logic       capture_in_o,       // Seen.
  input wire logic       capture_sel_o,      // Seen.
  input wire logic       cmp_irq_o           // Seen.
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  property p_irq_gate; cmp_irq_o |-> $past(global_irq_en_i); endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without global enable");
  property p_irq_drop; !global_irq_en_i |=> !cmp_irq_o; endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("irq kept after global off");
  property p_mux_gate; neg_mux_sel_o |-> !$past(converter_enable_i); endproperty
  a_mux_gate: assert property (p_mux_gate) else $error("mux chosen with converter on");
  property p_route_off; !capture_sel_o && !$past(capture_sel_o) |-> !capture_in_o; endproperty
  a_route_off: assert property (p_route_off) else $error("capture driven without route");
  property p_route_on; (capture_sel_o && !cmp_power_off_o && cmp_raw_i) [*4] |-> capture_in_o; endproperty
  a_route_on: assert property (p_route_on) else $error("result late at capture");
  property p_off_quiet; cmp_power_off_o [*4] |-> !capture_in_o; endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("result while disabled");
  property p_bg_write; $changed(bandgap_sel_o) |-> ($past(pready_o) && $past(pwrite_i))
    || ($past(pready_o, 2) && $past(pwrite_i, 2)); endproperty
  a_bg_write: assert property (p_bg_write) else $error("bandgap select moved alone");
  property p_ch_write; $changed(neg_channel_o) |-> ($past(pready_o) && $past(pwrite_i))
    || ($past(pready_o, 2) && $past(pwrite_i, 2)); endproperty
  a_ch_write: assert property (p_ch_write) else $error("channel moved alone");
endmodule

bind comparator_event_control comparator_event_control_monitor comparator_event_control_monitor_i (
  .core_clk_i, .rst_i, .pwrite_i, .pready_o, .cmp_raw_i, .converter_enable_i, .global_irq_en_i,
  .bandgap_sel_o, .neg_mux_sel_o, .neg_channel_o, .cmp_power_off_o, .capture_in_o, .capture_sel_o, .cmp_irq_o);

// [dv/test_comparator_event_control.sv]
/* Self-checking bench for the comparator event block over APB.
   Assumes the analog model steers cmp_raw_i from the select outputs. */
module test_comparator_event_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CT = cmp_event_pkg::OFF_CTRL_STATUS, MX = cmp_event_pkg::OFF_MUX_CTRL;
  localparam logic [7:0] ST = cmp_event_pkg::OFF_IRQ_STATUS, MK = cmp_event_pkg::OFF_IRQ_MASK;
  logic core_clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, pready_o, pslverr_o, cmp_raw_i;
  logic converter_enable_i = 0, global_irq_en_i = 0, irq_ack_i = 0, bandgap_sel_o, neg_mux_sel_o, e;
  logic cmp_power_off_o, capture_in_o, capture_sel_o, cmp_irq_o, irq_o;
  logic [7:0]  paddr_i = 8'h00;
  logic [2:0]  neg_channel_o;
  logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, q;
  real         pos_v = 0.0;
  int          err_total = 0, n_checks = 0;
  always #4 core_clk_i = ~core_clk_i;
  comparator_event_control comparator_event_control_i (.core_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .cmp_raw_i, .converter_enable_i, .global_irq_en_i,
    .irq_ack_i, .bandgap_sel_o, .neg_mux_sel_o, .neg_channel_o, .cmp_power_off_o, .capture_in_o,
    .capture_sel_o, .cmp_irq_o, .irq_o);
  analog_front_model analog_front_model_i (.bandgap_sel_i(bandgap_sel_o), .neg_mux_sel_i(neg_mux_sel_o),
    .neg_channel_i(neg_channel_o), .power_off_i(cmp_power_off_o), .pos_pin_v_i(pos_v), .neg_pin_v_i(1.0),
    .cmp_raw_o(cmp_raw_i));
  task automatic chk(input string n, input logic [31:0] s, x);
    n_checks++;
    if (s !== x) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // Holds the request until pready is seen high, for at most 20 cycles; a missing answer counts as a mismatch.
  task automatic apb(input logic w, input logic [7:0] a, d);
    int k;
    k = 0;
    @(posedge core_clk_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h00_0000, d};
    @(posedge core_clk_i);
    penable_i <= 1;
    do begin
      @(posedge core_clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    if (pready_o !== 1'b1) err_total++;
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask
  task automatic ctl(input logic r, f, input logic [1:0] m);
    apb(0, CT, 8'h00);
    chk("ctrl", q, {26'h000_0000, r, f, 2'b10, m});
  endtask
  task automatic wrap_up;
    if (err_total == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    cyc(5);
    rst_i <= 0;
    apb(0, CT, 8'h00);
    chk("ctrl_reset", q, 0);
    apb(0, MX, 8'h00);
    chk("mux_reset", q, 0);
    apb(0, 8'h10, 8'h00);
    chk("unmapped", {q[30:0], e}, 1);
    pos_v = 1.8;
    for (int c = 0; c < 8; c++) begin
      apb(1, MX, 8'h08 | 8'(c));
      cyc(4);
      chk("mux_sel", neg_mux_sel_o, 1);
      chk("channel", neg_channel_o, c);
      apb(0, CT, 8'h00);
      chk("ch_result", q[5], c < 4);
    end
    converter_enable_i <= 1;
    cyc(4);
    chk("mux_blocked", neg_mux_sel_o, 0);
    apb(0, CT, 8'h00);
    chk("pin_result", q[5], 1);
    converter_enable_i <= 0;
    // The mux still points at the top channel; hand the minus input back to the pin.
    apb(1, MX, 8'h00);
    pos_v = 0.0;
    apb(1, CT, 8'h60);
    cyc(4);
    apb(0, CT, 8'h00);
    chk("bandgap", {q[6:5], bandgap_sel_o}, 3'b111);
    apb(1, CT, 8'h20);
    cyc(4);
    apb(0, CT, 8'h00);
    chk("result_ro", q[6:5], 2'b00);
    apb(1, CT, 8'h04);
    pos_v = 2.0;
    cyc(6);
    chk("capture_on", capture_in_o, 1);
    apb(1, CT, 8'h80);
    cyc(4);
    apb(0, CT, 8'h00);
    chk("disabled", {q[7:5], cmp_power_off_o, capture_in_o}, 5'b10010);
    apb(1, CT, 8'h00);
    pos_v = 0.0;
    apb(1, MK, 8'h03);
    apb(0, ST, 8'h00);
    global_irq_en_i <= 1;
    for (int m = 0; m < 4; m++) begin
      apb(1, CT, 8'h10 | 8'(m));
      apb(1, CT, 8'h08 | 8'(m));
      pos_v = 2.0;
      cyc(6);
      ctl(1, m == 0 || m == 3, 2'(m));
      chk("irq_req", cmp_irq_o, m == 0 || m == 3);
      apb(1, CT, 8'h08 | 8'(m));
      ctl(1, m == 0 || m == 3, 2'(m));
      irq_ack_i <= 1;
      cyc(1);
      irq_ack_i <= 0;
      cyc(3);
      ctl(1, 0, 2'(m));
      pos_v = 0.0;
      cyc(6);
      ctl(0, m == 0 || m == 2, 2'(m));
      global_irq_en_i <= 0;
      cyc(3);
      chk("irq_blocked", cmp_irq_o, 0);
      global_irq_en_i <= 1;
    end
    chk("irq_line", irq_o, 1);
    apb(0, ST, 8'h00);
    chk("status", q, 3);
    apb(0, ST, 8'h00);
    chk("status_clear", {q[30:0], irq_o}, 0);
    apb(1, MK, 8'h00);
    pos_v = 2.0;
    cyc(6);
    chk("irq_masked", irq_o, 0);
    wrap_up();
  end
  initial begin
    cyc(20000);
    err_total++;
    wrap_up();
  end
endmodule
